// *** common/pulse_ctl_pkg.sv ***
package pulse_ctl_pkg;
   // AXI4-Lite register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL_LOW   = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h08;
   localparam logic [7:0] ADDR_GEN_STATE  = 8'h0c;
   localparam logic [7:0] ADDR_RMW_READ   = 8'h10;
   localparam int ADDR_W = 8;

   // Fields of pulse_status_control_low
   localparam int BIT_FALL_STOP  = 7;
   localparam int BIT_RISE_START = 6;
   localparam int BIT_IRQ_EN     = 5;
   localparam int BIT_PENDING    = 4;
   localparam int BIT_SRC_HI     = 3;
   localparam int BIT_SRC_LO     = 2;
   localparam int BIT_PIN_EN     = 1;
   localparam int BIT_POLARITY   = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Sticky event bits of the status and mask registers
   localparam int EV_START = 0;
   localparam int EV_STOP  = 1;
   localparam int EV_PEND  = 2;
   localparam int EV_W     = 3;
   localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

   typedef enum logic [1:0] {
      SRC_TRIGGER, SRC_BORROW, SRC_EDGE, SRC_BORROW_EDGE
   } irq_source_t;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pulse_ctl_pkg

// *** core/pulse_gen_trigger_irq_ctl.sv ***
`timescale 1ns/1ps
// Function
// R1 - Fall-stop enable 1: falling trigger edge stops generation; 0: ignored.
// R2 - Rise-start enable 1: rising trigger edge starts generation; 0: ignored.
// R3 - Request enable gates the interrupt request; 0 blocks, 1 permits.
// R4 - Pending flag set by hardware on the selected interrupt event.
// R5 - Writing 0 clears pending flag; writing 1 leaves it unchanged.
// R6 - Read-modify-write reads of pending flag return 1.
// R7 - Source 00: pin trigger, software trigger or retrigger sets pending.
// R8 - Source 01: only counter borrow sets pending.
// R9 - Source 10: active output edge; 11: that edge or borrow.
// R10 - Pin enable 1: pin driven by the pulse output.
// R11 - Pin enable 0: pin released to general-purpose port.
// R12 - Normal polarity: start low, high at duty match, low on borrow.
// R13 - Polarity 1: exact inverse of the normal waveform.
// R14 - Request asserted while pending and request enable both 1.
// R15 - Request ORed with the position compare unit request.
// R16 - Pin trigger restarts a running count, whatever the retrigger enable.
// R17 - Edges enables 11: rise starts, fall halts, next rise restarts.
// R18 - Trigger pin synchronised, edge-detected, single-cycle pulses.
module pulse_gen_trigger_irq_ctl
   import pulse_ctl_pkg::*;
(
   input  wire logic                           CLK,
   input  wire logic                           SYS_RST,
   input  wire logic [pulse_ctl_pkg::ADDR_W-1:0] AWADDR,
   input  wire logic                           AWVALID,
   output logic                                AWREADY,
   input  wire logic [31:0]                    WDATA,
   input  wire logic [3:0]                     WSTRB,
   input  wire logic                           WVALID,
   output logic                                WREADY,
   output logic [1:0]                          BRESP,
   output logic                                BVALID,
   input  wire logic                           BREADY,
   input  wire logic [pulse_ctl_pkg::ADDR_W-1:0] ARADDR,
   input  wire logic                           ARVALID,
   output logic                                ARREADY,
   output logic [31:0]                         RDATA,
   output logic [1:0]                          RRESP,
   output logic                                RVALID,
   input  wire logic                           RREADY,
   input  wire logic                           TRIGGER_PIN,
   input  wire logic                           SOFT_TRIGGER,
   input  wire logic                           SOFT_RETRIGGER_ENABLE,
   input  wire logic                           RETRIGGER,
   input  wire logic                           COUNTER_BORROW,
   input  wire logic                           DUTY_MATCH,
   input  wire logic                           POSITION_COMPARE_IRQ,
   output logic                                GEN_START,
   output logic                                GEN_STOP,
   output logic                                PULSE_OUTPUT,
   output logic                                PULSE_OUTPUT_OE,
   output logic                                IRQ_REQUEST,
   output logic                                IRQ
);
   import pulse_ctl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0]      ctrl_reg;
   logic [7:0]      ctrl_next;
   logic [EV_W-1:0] status_reg;
   logic [EV_W-1:0] status_next;
   logic [EV_W-1:0] mask_reg;
   logic            running_reg;
   logic            wave_reg;
   logic            wave_next;
   logic            pin_meta_reg;
   logic            pin_sync_reg;
   logic            pin_prev_reg;

   logic            aw_held_reg;
   logic            w_held_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [31:0]     w_data_reg;
   logic [3:0]      w_strb_reg;
   logic            bvalid_reg;
   logic [1:0]      bresp_reg;
   logic            rvalid_reg;
   logic [31:0]     rdata_reg;
   logic [1:0]      rresp_reg;

   function automatic logic addr_known(input logic [ADDR_W-1:0] a);
      return a == ADDR_CTRL_LOW || a == ADDR_IRQ_STATUS ||
             a == ADDR_IRQ_MASK || a == ADDR_GEN_STATE ||
             a == ADDR_RMW_READ;
   endfunction : addr_known

   ////////////////////////////////////////////////////////////////////////
   // Trigger pin synchroniser and edge detect
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
      end else begin
         pin_meta_reg <= TRIGGER_PIN; // R18
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   wire pin_rise = pin_sync_reg & ~pin_prev_reg; // R18
   wire pin_fall = ~pin_sync_reg & pin_prev_reg; // R18
   wire fall_stop_enable   = ctrl_reg[BIT_FALL_STOP];
   wire rising_start_enable = ctrl_reg[BIT_RISE_START];
   wire irq_request_enable = ctrl_reg[BIT_IRQ_EN];
   wire pending_flag       = ctrl_reg[BIT_PENDING];
   wire pin_drive_enable   = ctrl_reg[BIT_PIN_EN];
   wire output_polarity    = ctrl_reg[BIT_POLARITY];
   wire irq_source_t src   = irq_source_t'(ctrl_reg[BIT_SRC_HI:BIT_SRC_LO]);

   // A pin start also restarts a running count, whatever SOFT_RETRIGGER_ENABLE says
   wire hw_start = rising_start_enable & pin_rise; // R2 R16 R17
   wire hw_stop  = fall_stop_enable & pin_fall;    // R1 R17
   wire sw_start = SOFT_TRIGGER & (~running_reg | SOFT_RETRIGGER_ENABLE);
   wire any_start = hw_start | sw_start | RETRIGGER;

   assign GEN_START = hw_start | sw_start;
   assign GEN_STOP  = hw_stop & ~hw_start;

   ////////////////////////////////////////////////////////////////////////
   // Normal-polarity waveform, then the polarity inversion
   always_comb begin
      wave_next = wave_reg;
      if (any_start || hw_stop)
         wave_next = 1'b0;          // R12
      else if (COUNTER_BORROW)
         wave_next = 1'b0;          // R12
      else if (DUTY_MATCH && running_reg)
         wave_next = 1'b1;          // R12
   end

   wire out_level  = wave_reg ^ output_polarity; // R13
   // Active edge is a rise of the normal waveform in either polarity
   wire out_edge   = wave_next & ~wave_reg;      // R9

   logic sel_event;
   always_comb begin
      unique case (src)
         SRC_TRIGGER:     sel_event = any_start;                  // R7
         SRC_BORROW:      sel_event = COUNTER_BORROW;             // R8
         SRC_EDGE:        sel_event = out_edge;                   // R9
         SRC_BORROW_EDGE: sel_event = out_edge | COUNTER_BORROW;  // R9
      endcase
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         running_reg <= 1'b0;
         wave_reg    <= 1'b0;
      end else begin
         running_reg <= any_start | (running_reg & ~GEN_STOP);
         wave_reg    <= wave_next;
      end
   end

   assign PULSE_OUTPUT    = out_level;        // R10
   assign PULSE_OUTPUT_OE = pin_drive_enable; // R10 R11

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path
   wire aw_take  = AWVALID & ~aw_held_reg & ~bvalid_reg;
   wire w_take   = WVALID & ~w_held_reg & ~bvalid_reg;
   wire wr_fire  = aw_held_reg & w_held_reg;
   wire wr_ctrl  = wr_fire & (aw_addr_reg == ADDR_CTRL_LOW) & w_strb_reg[0];
   wire wr_mask  = wr_fire & (aw_addr_reg == ADDR_IRQ_MASK) & w_strb_reg[0];
   wire ar_take  = ARVALID & ~rvalid_reg;
   wire rd_stat  = ar_take & (ARADDR == ADDR_IRQ_STATUS);

   assign AWREADY = ~aw_held_reg & ~bvalid_reg;
   assign WREADY  = ~w_held_reg & ~bvalid_reg;
   assign ARREADY = ~rvalid_reg;

   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = w_data_reg[7:0];
         // Writing 1 keeps the flag; only 0 clears
         ctrl_next[BIT_PENDING] = pending_flag & w_data_reg[BIT_PENDING]; // R5
      end
      if (sel_event)
         ctrl_next[BIT_PENDING] = 1'b1; // R4
   end

   // Set wins over the read that clears
   always_comb begin
      status_next = rd_stat ? '0 : status_reg;
      if (GEN_START)
         status_next[EV_START] = 1'b1;
      if (GEN_STOP)
         status_next[EV_STOP] = 1'b1;
      if (sel_event)
         status_next[EV_PEND] = 1'b1;
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         w_strb_reg  <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= AWADDR;
         end
         if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= WDATA;
            w_strb_reg <= WSTRB;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= addr_known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && BREADY) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ctrl_reg   <= CTRL_RESET;
         mask_reg   <= MASK_RESET;
         status_reg <= '0;
      end else begin
         ctrl_reg   <= ctrl_next;
         status_reg <= status_next;
         if (wr_mask)
            mask_reg <= w_data_reg[EV_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path; the RMW alias reads the flag as 1
   logic [31:0] rd_word;
   always_comb begin
      rd_word = '0;
      unique case (ARADDR)
         ADDR_CTRL_LOW:   rd_word[7:0] = ctrl_reg;
         ADDR_IRQ_STATUS: rd_word[EV_W-1:0] = status_reg;
         ADDR_IRQ_MASK:   rd_word[EV_W-1:0] = mask_reg;
         ADDR_GEN_STATE:  rd_word[1:0] = {wave_reg, running_reg};
         ADDR_RMW_READ:   rd_word[7:0] = ctrl_reg | 8'(1 << BIT_PENDING); // R6
         default:         rd_word = '0;
      endcase
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_word;
         rresp_reg  <= addr_known(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && RREADY) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign BVALID = bvalid_reg;
   assign BRESP  = bresp_reg;
   assign RVALID = rvalid_reg;
   assign RDATA  = rdata_reg;
   assign RRESP  = rresp_reg;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt outputs
   assign IRQ_REQUEST = (pending_flag & irq_request_enable)   // R3 R14
                        | POSITION_COMPARE_IRQ;               // R15
   assign IRQ = |(status_reg & mask_reg);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   chk_fall_stop: assert property (@(posedge CLK) disable iff (SYS_RST) // R1
      (pin_fall && fall_stop_enable) |-> GEN_STOP)
      else $error("falling edge did not stop");
   chk_rise_start: assert property (@(posedge CLK) disable iff (SYS_RST) // R2
      (!rising_start_enable && !SOFT_TRIGGER) |-> !GEN_START)
      else $error("start without enable");
   chk_irq_gate: assert property (@(posedge CLK) disable iff (SYS_RST) // R3
      (!irq_request_enable && !POSITION_COMPARE_IRQ) |-> !IRQ_REQUEST)
      else $error("request not gated");
   chk_pend_set: assert property (@(posedge CLK) disable iff (SYS_RST) // R4
      sel_event |=> pending_flag)
      else $error("pending not set");
   chk_pend_keep: assert property (@(posedge CLK) disable iff (SYS_RST) // R5
      (pending_flag && wr_ctrl && w_data_reg[BIT_PENDING]) |=> pending_flag)
      else $error("write 1 cleared flag");
   chk_rmw_read: assert property (@(posedge CLK) disable iff (SYS_RST) // R6
      (ar_take && ARADDR == ADDR_RMW_READ) |=> RDATA[BIT_PENDING])
      else $error("rmw read not 1");
   chk_borrow_src: assert property (@(posedge CLK) disable iff (SYS_RST) // R8
      (src == SRC_BORROW && !COUNTER_BORROW) |-> !sel_event)
      else $error("borrow source leaked");
   chk_pin_drive: assert property (@(posedge CLK) disable iff (SYS_RST) // R10
      PULSE_OUTPUT_OE == pin_drive_enable)
      else $error("pin enable wrong");
   chk_wave_low: assert property (@(posedge CLK) disable iff (SYS_RST) // R12
      COUNTER_BORROW |=> !wave_reg)
      else $error("borrow did not end pulse");
   chk_polarity: assert property (@(posedge CLK) disable iff (SYS_RST) // R13
      PULSE_OUTPUT == (wave_reg ^ output_polarity))
      else $error("polarity wrong");
   chk_irq_req: assert property (@(posedge CLK) disable iff (SYS_RST) // R14
      (pending_flag && irq_request_enable) |-> IRQ_REQUEST)
      else $error("request missing");
   chk_sync_edge: assert property (@(posedge CLK) disable iff (SYS_RST) // R18
      pin_rise |=> !pin_rise)
      else $error("edge pulse too long");

   // Raw pin steps; the edge pulse trails them by the two sync flops
   sequence pin_went_high;
      !TRIGGER_PIN ##1 TRIGGER_PIN;
   endsequence
   sequence pin_went_low;
      TRIGGER_PIN ##1 !TRIGGER_PIN;
   endsequence
   chk_rise_lag: assert property (@(posedge CLK) disable iff (SYS_RST) // R18
      pin_went_high |-> ##2 pin_rise)
      else $error("rising edge pulse late");
   chk_fall_lag: assert property (@(posedge CLK) disable iff (SYS_RST) // R18
      pin_went_low |-> ##2 pin_fall)
      else $error("falling edge pulse late");
   chk_rise_go: assert property (@(posedge CLK) disable iff (SYS_RST) // R17
      (pin_rise && rising_start_enable) |-> (GEN_START && !GEN_STOP))
      else $error("rising edge did not start");
   chk_fall_halt: assert property (@(posedge CLK) disable iff (SYS_RST) // R17
      (GEN_STOP && !SOFT_TRIGGER && !RETRIGGER) |=> !running_reg)
      else $error("falling edge did not halt");
   chk_pin_rerun: assert property (@(posedge CLK) disable iff (SYS_RST) // R16
      (pin_rise && rising_start_enable && running_reg) |-> GEN_START)
      else $error("pin trigger did not restart");
   chk_pend_clear: assert property (@(posedge CLK) disable iff (SYS_RST) // R5
      (wr_ctrl && !w_data_reg[BIT_PENDING] && !sel_event) |=> !pending_flag)
      else $error("write 0 kept flag");
   chk_src_trigger: assert property (@(posedge CLK) disable iff (SYS_RST) // R7
      (src == SRC_TRIGGER && (GEN_START || RETRIGGER)) |=> pending_flag)
      else $error("trigger did not set flag");
   chk_src_borrow: assert property (@(posedge CLK) disable iff (SYS_RST) // R8
      (src == SRC_BORROW && COUNTER_BORROW) |=> pending_flag)
      else $error("borrow did not set flag");
   chk_src_edge: assert property (@(posedge CLK) disable iff (SYS_RST) // R9
      (src == SRC_EDGE && !wave_reg) ##1 wave_reg |-> pending_flag)
      else $error("output edge did not set flag");
   chk_src_both: assert property (@(posedge CLK) disable iff (SYS_RST) // R9
      (src == SRC_BORROW_EDGE && COUNTER_BORROW) |=> pending_flag)
      else $error("borrow in mixed source missed");
   chk_pin_free: assert property (@(posedge CLK) disable iff (SYS_RST) // R11
      !pin_drive_enable |-> !PULSE_OUTPUT_OE)
      else $error("pin not released");
   chk_wave_start: assert property (@(posedge CLK) disable iff (SYS_RST) // R12
      GEN_START |=> !wave_reg)
      else $error("start did not reset wave");
   chk_wave_high: assert property (@(posedge CLK) disable iff (SYS_RST) // R12
      (DUTY_MATCH && running_reg && !COUNTER_BORROW && !any_start
       && !hw_stop) |=> wave_reg)
      else $error("duty match did not raise wave");
   chk_shared_irq: assert property (@(posedge CLK) disable iff (SYS_RST) // R15
      POSITION_COMPARE_IRQ |-> IRQ_REQUEST)
      else $error("shared request lost");
   chk_irq_line: assert property (@(posedge CLK) disable iff (SYS_RST)
      (GEN_START && mask_reg[EV_START] && !wr_mask) |=> IRQ)
      else $error("unmasked event left irq low");
   chk_bvalid_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
      (BVALID && !BREADY) |=> BVALID)
      else $error("write response dropped");
   chk_rvalid_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
      (RVALID && !RREADY) |=> (RVALID && $stable(RDATA)))
      else $error("read response dropped");
endmodule : pulse_gen_trigger_irq_ctl

// *** verif/pulse_far_model.sv ***
`timescale 1ns/1ps
module pulse_far_model (
   input  wire logic clk,
   input  wire logic irq_request,
   output logic      trigger_pin,
   output logic      pos_irq
);
   int   n_irq    = 0;
   logic irq_prev = 1'b0;

   // Pin is a level held by the outside world, never released
   initial begin
      trigger_pin = 1'b0;
      pos_irq = 1'b0;
   end

   // Controller side: counts request rises, mid-cycle where settled
   always @(negedge clk) begin
      if (irq_request === 1'b1 && !irq_prev) n_irq++;
      irq_prev <= (irq_request === 1'b1);
   end

   ////////////////////////////////////////////////////////////////////////
   // Long hold covers the two-flop synchroniser and edge detector
   task automatic drive_pin(input logic v);
      @(posedge clk);
      trigger_pin <= v;
      repeat (6) @(posedge clk);
   endtask : drive_pin

   // Request of the other unit sharing the same controller line
   task automatic set_pos(input logic v);
      @(posedge clk);
      pos_irq <= v;
      repeat (2) @(posedge clk);
   endtask : set_pos
endmodule : pulse_far_model

// *** verif/pulse_gen_trigger_irq_ctl_tb.sv ***
`timescale 1ns/1ps
module pulse_gen_trigger_irq_ctl_tb;
   import pulse_ctl_pkg::*;
   logic              CLK, SYS_RST;
   logic [ADDR_W-1:0] AWADDR, ARADDR;
   logic [31:0]       WDATA, RDATA, rdat;
   logic [3:0]        WSTRB;
   logic [1:0]        BRESP, RRESP, resp;
   logic              AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic              ARVALID, ARREADY, RVALID, RREADY;
   logic              TRIGGER_PIN, SOFT_RETRIGGER_ENABLE;
   logic              POSITION_COMPARE_IRQ, GEN_START, GEN_STOP;
   logic              PULSE_OUTPUT, PULSE_OUTPUT_OE, IRQ_REQUEST, IRQ;
   logic [3:0]        ev;
   int                failures, n_compared, n_start, n_stop;
   int                src_tab [6] = '{0, 1, 1, 2, 2, 3};
   int                kind_tab [6] = '{0, 0, 1, 1, 2, 1};
   int                pend_tab [6] = '{1, 0, 1, 0, 1, 1};
   int                wave_tab [6] = '{0, 0, 0, 0, 1, 0};

   pulse_gen_trigger_irq_ctl i_pulse_gen_trigger_irq_ctl (
      .CLK(CLK), .SYS_RST(SYS_RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
      .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
      .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .TRIGGER_PIN(TRIGGER_PIN), .SOFT_TRIGGER(ev[3]),
      .SOFT_RETRIGGER_ENABLE(SOFT_RETRIGGER_ENABLE), .RETRIGGER(ev[0]),
      .COUNTER_BORROW(ev[1]), .DUTY_MATCH(ev[2]),
      .POSITION_COMPARE_IRQ(POSITION_COMPARE_IRQ), .GEN_START(GEN_START),
      .GEN_STOP(GEN_STOP), .PULSE_OUTPUT(PULSE_OUTPUT),
      .PULSE_OUTPUT_OE(PULSE_OUTPUT_OE), .IRQ_REQUEST(IRQ_REQUEST),
      .IRQ(IRQ));

   pulse_far_model i_pulse_far_model (
      .clk(CLK), .irq_request(IRQ_REQUEST), .trigger_pin(TRIGGER_PIN),
      .pos_irq(POSITION_COMPARE_IRQ));

   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   // Start and stop are one-cycle pulses, counted mid-cycle
   always @(negedge CLK) begin
      if (GEN_START === 1'b1) n_start++;
      if (GEN_STOP === 1'b1) n_stop++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Handshakes sampled mid-cycle: that is what the next edge takes
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int   n;
      logic aw, w, b;
      @(posedge CLK);
      AWADDR <= a;
      AWVALID <= 1'b1;
      WDATA <= d;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      b = 1'b0;
      for (n = 0; n < 50 && !b; n++) begin
         @(negedge CLK);
         aw = AWVALID & AWREADY;
         w = WVALID & WREADY;
         b = BVALID & BREADY;
         resp = BRESP;
         @(posedge CLK);
         if (aw) AWVALID <= 1'b0;
         if (w) WVALID <= 1'b0;
         if (b) BREADY <= 1'b0;
      end
      if (!b) begin
         failures++;
         finish_test();
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      int   n;
      logic ar, rv;
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      rv = 1'b0;
      for (n = 0; n < 50 && !rv; n++) begin
         @(negedge CLK);
         ar = ARVALID & ARREADY;
         rv = RVALID & RREADY;
         rdat = RDATA;
         resp = RRESP;
         @(posedge CLK);
         if (ar) ARVALID <= 1'b0;
         if (rv) RREADY <= 1'b0;
      end
      if (!rv) begin
         failures++;
         finish_test();
      end
      chk($sformatf("read %h", a), exp, rdat);
   endtask : rd

   task automatic pulse(input int k);
      @(posedge CLK);
      ev <= 4'h1 << k;
      @(posedge CLK);
      ev <= 4'h0;
      repeat (3) @(posedge CLK);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {AWADDR, ARADDR, WDATA, AWVALID, WVALID, BREADY} = '0;
      {ARVALID, RREADY, SOFT_RETRIGGER_ENABLE, ev} = '0;
      WSTRB = 4'hf;
      {failures, n_compared, n_start, n_stop} = '0;
      SYS_RST = 1'b1;
      repeat (5) @(posedge CLK);
      SYS_RST <= 1'b0;
      rd(ADDR_CTRL_LOW, 32'h00);
      rd(ADDR_IRQ_MASK, 32'h00);
      rd(8'h40, 32'h00);
      chk("unmapped read resp", RESP_SLVERR, resp);
      wr(8'h40, 32'h00);
      chk("unmapped write resp", RESP_SLVERR, resp);
      wr(ADDR_IRQ_MASK, 32'h07);
      rd(ADDR_IRQ_MASK, 32'h07);
      // No byte lane enabled: the write must not land
      WSTRB <= 4'h0;
      wr(ADDR_CTRL_LOW, 32'hff);
      WSTRB <= 4'hf;
      rd(ADDR_CTRL_LOW, 32'h00);
      // Edges ignored while both edge enables are clear
      wr(ADDR_CTRL_LOW, 32'h20);
      i_pulse_far_model.drive_pin(1'b1);
      i_pulse_far_model.drive_pin(1'b0);
      chk("starts", 0, n_start);
      chk("stops", 0, n_stop);
      rd(ADDR_IRQ_STATUS, 32'h00);
      wr(ADDR_CTRL_LOW, 32'he0);
      i_pulse_far_model.drive_pin(1'b1);
      chk("starts", 1, n_start);
      chk("irq request", 1, IRQ_REQUEST);
      chk("irq", 1, IRQ);
      i_pulse_far_model.drive_pin(1'b0);
      chk("stops", 1, n_stop);
      i_pulse_far_model.drive_pin(1'b1);
      chk("restarts", 2, n_start);
      rd(ADDR_CTRL_LOW, 32'hf0);
      wr(ADDR_CTRL_LOW, 32'hf0);
      rd(ADDR_CTRL_LOW, 32'hf0);
      wr(ADDR_CTRL_LOW, 32'he0);
      rd(ADDR_CTRL_LOW, 32'he0);
      chk("irq request", 0, IRQ_REQUEST);
      rd(ADDR_RMW_READ, 32'hf0);
      rd(ADDR_IRQ_STATUS, 32'h07);
      rd(ADDR_IRQ_STATUS, 32'h00);
      chk("irq", 0, IRQ);
      // Masked event stays sticky but keeps the line low
      wr(ADDR_IRQ_MASK, 32'h00);
      i_pulse_far_model.drive_pin(1'b0);
      chk("irq", 0, IRQ);
      rd(ADDR_IRQ_STATUS, 32'h02);
      wr(ADDR_CTRL_LOW, 32'h42);
      i_pulse_far_model.drive_pin(1'b1);
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_CTRL_LOW, 32'h42 | (src_tab[i] << 2));
         pulse(kind_tab[i]);
         rd(ADDR_CTRL_LOW,
            32'h42 | (src_tab[i] << 2) | (pend_tab[i] << 4));
         chk("wave", wave_tab[i], PULSE_OUTPUT);
      end
      chk("irq request", 0, IRQ_REQUEST);
      chk("pin enable", 1, PULSE_OUTPUT_OE);
      wr(ADDR_CTRL_LOW, 32'h49);
      chk("inverted", 1, PULSE_OUTPUT);
      chk("pin enable", 0, PULSE_OUTPUT_OE);
      pulse(2);
      chk("inverted", 0, PULSE_OUTPUT);
      rd(ADDR_CTRL_LOW, 32'h59);
      // Software trigger: free when idle, gated by retrigger when running
      wr(ADDR_CTRL_LOW, 32'hc0);
      i_pulse_far_model.drive_pin(1'b0);
      chk("stops", 3, n_stop);
      pulse(3);
      chk("starts", 4, n_start);
      rd(ADDR_CTRL_LOW, 32'hd0);
      wr(ADDR_CTRL_LOW, 32'hc0);
      pulse(3);
      rd(ADDR_CTRL_LOW, 32'hc0);
      SOFT_RETRIGGER_ENABLE <= 1'b1;
      pulse(3);
      chk("starts", 5, n_start);
      rd(ADDR_CTRL_LOW, 32'hd0);
      SOFT_RETRIGGER_ENABLE <= 1'b0;
      i_pulse_far_model.set_pos(1'b1);
      chk("shared request", 1, IRQ_REQUEST);
      i_pulse_far_model.set_pos(1'b0);
      chk("shared request", 0, IRQ_REQUEST);
      chk("irq rises", 2, i_pulse_far_model.n_irq);
      finish_test();
   end
endmodule : pulse_gen_trigger_irq_ctl_tb
